// [rtl/llc_pkg.sv]
// package: register map, limits and carriers of the two-channel limit checker
// Functional notes
// - two channels, each with own settings and results
// - upper limit below lower limit is refused
// - upper and lower limits checked together
// - each measured value judged against range
// - no alert unless interrupt mask enables it
// - violations reach status and interrupt output
// - fail read gives 1 on violation, else 0
// - fail flag sticky since enable or clear
// - violation count kept since enable or clear
// - clear command zeroes flag and count unless a violation comes in its cycle
// - lower limit -299.99..299.99, default -299.99
// - upper limit -299.99..299.99, default 299.99
// - per-channel enable, off at reset
// - limit reads return stored values
// - sensor check only on single-sensor channels
package llc_pkg;
    localparam int NUM_CH = 2;
    localparam int VAL_W = 16;
    // limit values in hundredths of a dB
    localparam logic signed [VAL_W-1:0] LIM_MIN = -16'sd29999;
    localparam logic signed [VAL_W-1:0] LIM_MAX = 16'sd29999;
    localparam logic signed [VAL_W-1:0] LOWER_RST = LIM_MIN;
    localparam logic signed [VAL_W-1:0] UPPER_RST = LIM_MAX;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CLEAR = 8'h04;
    localparam logic [7:0] ADDR_FAIL = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ADDR_SENSOR = 8'h14;
    localparam logic [7:0] ADDR_CH_BASE = 8'h20;
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [7:0] OFS_LOWER = 8'h00;
    localparam logic [7:0] OFS_UPPER = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;

    // control register fields
    localparam int CTRL_EN_LSB = 0;
    localparam int CTRL_SRC_LSB = 4;
    localparam int SRC_W = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SRC_SENSOR_A,
        SRC_SENSOR_B,
        SRC_COMBINED
    } llc_src_e;

    // one measured sample for one channel
    typedef struct packed {
        logic valid;
        logic signed [VAL_W-1:0] value;
    } llc_meas_s;
endpackage : llc_pkg

// [rtl/llc_limit_checker.sv]
// limit checker: two channels, AXI4-Lite registers, sticky fail, counts, interrupt
`timescale 1ns/1ps
module llc_limit_checker #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // measured samples, one per channel
    input wire llc_pkg::llc_meas_s [llc_pkg::NUM_CH-1:0] meas_i,
    // AXI4-Lite write address and data
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // interrupt and live flags
    output logic irq_o,
    output logic [llc_pkg::NUM_CH-1:0] fail_o
);
    localparam int N = llc_pkg::NUM_CH;
    localparam int VW = llc_pkg::VAL_W;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge_strb

    function automatic logic [31:0] sext(input logic signed [VW-1:0] v);
        return {{(32-VW){v[VW-1]}}, v};
    endfunction : sext

    // value fits the limit range once taken as a signed word
    function automatic logic in_range(input logic [31:0] v);
        return $signed(v) >= $signed(sext(llc_pkg::LIM_MIN)) && $signed(v) <= $signed(sext(llc_pkg::LIM_MAX));
    endfunction : in_range

    function automatic logic [7:0] ch_addr(input int ch, input logic [7:0] ofs);
        return 8'(llc_pkg::ADDR_CH_BASE + 8'(ch) * llc_pkg::CH_STRIDE + ofs);
    endfunction : ch_addr

    ////////////////////////////////////////////////////////////////////////////
    // per-channel state
    logic [N-1:0] en_reg;
    logic [N-1:0][llc_pkg::SRC_W-1:0] src_reg;
    logic signed [VW-1:0] lower_reg [N];
    logic signed [VW-1:0] upper_reg [N];
    logic [CNT_W-1:0] count_reg [N];
    logic [N-1:0] fail_reg;
    logic [N-1:0] stat_reg;
    logic [N-1:0] mask_reg;

    logic aw_got_reg, w_got_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg;
    logic [31:0] rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order, applied when both held
    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready = !w_got_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    logic wr_fire;
    assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
            end
        end
    end

    // decode and legality of the pending write
    logic wr_err;
    logic [N-1:0] wr_lower, wr_upper, wr_clear;
    logic [31:0] lower_new [N];
    logic [31:0] upper_new [N];
    logic wr_ctrl, wr_stat, wr_mask;

    always_comb begin
        wr_err = 1'b1;
        wr_ctrl = 1'b0;
        wr_stat = 1'b0;
        wr_mask = 1'b0;
        wr_lower = '0;
        wr_upper = '0;
        wr_clear = '0;
        unique case (awaddr_reg)
            llc_pkg::ADDR_CTRL: begin
                wr_ctrl = 1'b1;
                wr_err = 1'b0;
            end
            llc_pkg::ADDR_CLEAR: begin
                wr_clear = wdata_reg[N-1:0] & {N{wstrb_reg[0]}};
                wr_err = 1'b0;
            end
            llc_pkg::ADDR_IRQ_STAT: begin
                wr_stat = 1'b1;
                wr_err = 1'b0;
            end
            llc_pkg::ADDR_IRQ_MASK: begin
                wr_mask = 1'b1;
                wr_err = 1'b0;
            end
            llc_pkg::ADDR_FAIL, llc_pkg::ADDR_SENSOR: begin
                wr_err = 1'b0;
            end
            default: begin
            end
        endcase
        for (int c = 0; c < N; c++) begin
            lower_new[c] = merge_strb(sext(lower_reg[c]), wdata_reg, wstrb_reg);
            upper_new[c] = merge_strb(sext(upper_reg[c]), wdata_reg, wstrb_reg);
            if (awaddr_reg == ch_addr(c, llc_pkg::OFS_COUNT)) begin
                wr_err = 1'b0;
            end
            if (awaddr_reg == ch_addr(c, llc_pkg::OFS_LOWER)) begin
                wr_err = !in_range(lower_new[c]) || $signed(lower_new[c]) > $signed(sext(upper_reg[c]));
                wr_lower[c] = !wr_err;
            end
            if (awaddr_reg == ch_addr(c, llc_pkg::OFS_UPPER)) begin
                wr_err = !in_range(upper_new[c]) || $signed(upper_new[c]) < $signed(sext(lower_reg[c]));
                wr_upper[c] = !wr_err;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= llc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_err ? llc_pkg::RESP_SLVERR : llc_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settings
    logic [N-1:0] en_rise;
    assign en_rise = {N{wr_fire && wr_ctrl && wstrb_reg[0]}} & wdata_reg[llc_pkg::CTRL_EN_LSB +: N] & ~en_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_reg <= '0;
            src_reg <= '0;
        end else if (wr_fire && wr_ctrl && wstrb_reg[0]) begin
            en_reg <= wdata_reg[llc_pkg::CTRL_EN_LSB +: N];
            src_reg <= wdata_reg[llc_pkg::CTRL_SRC_LSB +: N*llc_pkg::SRC_W];
        end
    end

    always_ff @(posedge clk_i) begin
        for (int c = 0; c < N; c++) begin
            if (rst_i) begin
                lower_reg[c] <= llc_pkg::LOWER_RST;
                upper_reg[c] <= llc_pkg::UPPER_RST;
            end else if (wr_fire) begin
                if (wr_lower[c]) begin
                    lower_reg[c] <= lower_new[c][VW-1:0];
                end
                if (wr_upper[c]) begin
                    upper_reg[c] <= upper_new[c][VW-1:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checking
    logic [N-1:0] viol;
    logic [N-1:0] restart;

    always_comb begin
        for (int c = 0; c < N; c++) begin
            viol[c] = en_reg[c] && meas_i[c].valid &&
                      (meas_i[c].value > upper_reg[c] || meas_i[c].value < lower_reg[c]);
            // clear or fresh enable restarts the channel
            restart[c] = (wr_fire && wr_clear[c]) || en_rise[c];
        end
    end

    always_ff @(posedge clk_i) begin
        for (int c = 0; c < N; c++) begin
            if (rst_i) begin
                fail_reg[c] <= 1'b0;
                count_reg[c] <= '0;
            end else if (restart[c]) begin
                // a violation in the clearing cycle still counts
                fail_reg[c] <= viol[c];
                count_reg[c] <= CNT_W'(viol[c]);
            end else if (viol[c]) begin
                fail_reg[c] <= 1'b1;
                if (count_reg[c] != '1) begin
                    count_reg[c] <= count_reg[c] + 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt: sticky status, write one to clear, set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_reg <= '0;
            mask_reg <= '0;
        end else begin
            stat_reg <= (stat_reg & ~({N{wr_fire && wr_stat && wstrb_reg[0]}} & wdata_reg[N-1:0])) | viol;
            if (wr_fire && wr_mask && wstrb_reg[0]) begin
                mask_reg <= wdata_reg[N-1:0];
            end
        end
    end

    // masked off by default, so no alert
    assign irq_o = |(stat_reg & mask_reg);
    assign fail_o = fail_reg;

    ////////////////////////////////////////////////////////////////////////////
    // read channel: answer one cycle after the address is taken
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = llc_pkg::RESP_OKAY;

    logic [31:0] rd_val;
    logic [1:0] sens_chk;

    // a sensor is checked only by a channel that measures it alone
    always_comb begin
        sens_chk = '0;
        for (int c = 0; c < N; c++) begin
            if (en_reg[c] && src_reg[c] == llc_pkg::SRC_SENSOR_A) begin
                sens_chk[0] = 1'b1;
            end
            if (en_reg[c] && src_reg[c] == llc_pkg::SRC_SENSOR_B) begin
                sens_chk[1] = 1'b1;
            end
        end
    end

    always_comb begin
        rd_val = 32'h0;
        unique case (s_axi_araddr[7:0])
            llc_pkg::ADDR_CTRL: rd_val = 32'({src_reg, 2'h0, en_reg});
            llc_pkg::ADDR_FAIL: rd_val = 32'(fail_reg);
            llc_pkg::ADDR_IRQ_STAT: rd_val = 32'(stat_reg);
            llc_pkg::ADDR_IRQ_MASK: rd_val = 32'(mask_reg);
            llc_pkg::ADDR_SENSOR: rd_val = 32'(sens_chk);
            default: begin
            end
        endcase
        for (int c = 0; c < N; c++) begin
            if (s_axi_araddr[7:0] == ch_addr(c, llc_pkg::OFS_LOWER)) begin
                rd_val = sext(lower_reg[c]);
            end
            if (s_axi_araddr[7:0] == ch_addr(c, llc_pkg::OFS_UPPER)) begin
                rd_val = sext(upper_reg[c]);
            end
            if (s_axi_araddr[7:0] == ch_addr(c, llc_pkg::OFS_COUNT)) begin
                rd_val = 32'(count_reg[c]);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_val;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_limit_order_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        upper_reg[0] >= lower_reg[0] && upper_reg[1] >= lower_reg[1])
        else $error("upper limit below lower limit");

    a_bad_upper_refused: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_fire && awaddr_reg == 8'h24 && wstrb_reg == 4'hf && $signed(wdata_reg) < $signed(sext(lower_reg[0]))
        |=> s_axi_bresp == llc_pkg::RESP_SLVERR && $stable(upper_reg[0]))
        else $error("illegal upper limit taken");

    a_viol_sets_fail: assert property (@(posedge clk_i) disable iff (rst_i)
        viol[0] |=> fail_reg[0] && stat_reg[0])
        else $error("violation did not set fail");

    a_fail_needs_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        !fail_reg[1] && !(en_reg[1] && meas_i[1].valid && (meas_i[1].value > upper_reg[1]
        || meas_i[1].value < lower_reg[1])) |=> !fail_reg[1])
        else $error("fail set without violation");

    a_count_steps: assert property (@(posedge clk_i) disable iff (rst_i)
        viol[0] && !restart[0] && count_reg[0] < 16'h00ff |=> count_reg[0] == $past(count_reg[0]) + 1'b1)
        else $error("count did not step");

    a_clear_restarts: assert property (@(posedge clk_i) disable iff (rst_i)
        restart[1] && !viol[1] |=> fail_reg[1] == 1'b0 && count_reg[1] == '0)
        else $error("clear left flag or count");

    a_off_no_count: assert property (@(posedge clk_i) disable iff (rst_i)
        !en_reg[0] && !restart[0] ##1 !en_reg[0] |-> $stable(count_reg[0]) && $stable(fail_reg[0]))
        else $error("disabled channel changed");

    a_reset_defaults: assert property (@(posedge clk_i)
        $past(rst_i) |-> en_reg == '0 && lower_reg[0] == llc_pkg::LOWER_RST && upper_reg[1] == llc_pkg::UPPER_RST)
        else $error("reset values wrong");

    a_irq_masked: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(irq_o) |-> ($past(viol) & mask_reg) != '0 || ($past(wr_fire) && $past(wr_mask)))
        else $error("alert without enabled violation");

    a_read_answer: assert property (@(posedge clk_i) disable iff (rst_i)
        s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == 8'h20 |=> s_axi_rvalid
        && $signed(s_axi_rdata) == $past(lower_reg[0]))
        else $error("lower limit read wrong");
endmodule : llc_limit_checker

// [bench/llc_host_model.sv]
// host controller model: AXI4-Lite master running one access at a time
`timescale 1ns/1ps
module llc_host_model (
    // clock
    input wire logic clk_i,
    // write channels
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_awaddr,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    // read channels
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    output logic [31:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 32'h0;
        s_axi_wdata = 32'h0;
        s_axi_araddr = 32'h0;
        s_axi_wstrb = 4'hf;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // caller picks address and data
    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk_i);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= {24'h0, addr};
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= data;
        while (!(aw_done && w_done)) begin
            @(posedge clk_i);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
                // released lines must not keep showing the old value
                s_axi_awaddr <= ~s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~s_axi_wdata;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge clk_i); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [7:0] addr, output logic [31:0] data);
        @(posedge clk_i);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= {24'h0, addr};
        do @(posedge clk_i); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~s_axi_araddr;
        s_axi_rready <= 1'b1;
        do @(posedge clk_i); while (!s_axi_rvalid);
        data = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask : axi_read
endmodule : llc_host_model

// [bench/tb.sv]
// testbench: register-level scenarios for the two-channel limit checker
`timescale 1ns/1ps
module tb;
    localparam int TIMEOUT_CYC = 20000;
    logic clk_i;
    logic rst_i;
    llc_pkg::llc_meas_s [llc_pkg::NUM_CH-1:0] meas;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, fail_flags;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    llc_limit_checker dut (.clk_i(clk_i), .rst_i(rst_i), .meas_i(meas),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .irq_o(irq), .fail_o(fail_flags));
    llc_host_model host (.clk_i(clk_i),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    // a hang counts as a mismatch
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == TIMEOUT_CYC) begin
            fails = fails + 1;
            print_verdict();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic rd_chk(input string name, input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        host.axi_read(addr, d);
        check(name, d, exp);
    endtask : rd_chk
    task automatic wr(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] exp);
        logic [1:0] r;
        host.axi_write(addr, data, r);
        check("bresp", {30'h0, r}, {30'h0, exp});
    endtask : wr
    // n back-to-back samples of value v on channel c
    task automatic sample(input int c, input int v, input int n);
        repeat (n) begin
            @(posedge clk_i);
            meas[c] <= '{1'b1, 16'(v)};
        end
        @(posedge clk_i);
        meas[c].valid <= 1'b0;
    endtask : sample
    function automatic logic [7:0] ca(input int c, input logic [7:0] ofs);
        return llc_pkg::ADDR_CH_BASE + 8'(c) * llc_pkg::CH_STRIDE + ofs;
    endfunction : ca
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_i = 1'b1;
        meas = '0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int c = 0; c < llc_pkg::NUM_CH; c++) begin
            rd_chk("lower_rst", ca(c, llc_pkg::OFS_LOWER), 32'(llc_pkg::LOWER_RST));
            rd_chk("upper_rst", ca(c, llc_pkg::OFS_UPPER), 32'(llc_pkg::UPPER_RST));
            rd_chk("count_rst", ca(c, llc_pkg::OFS_COUNT), 32'h0);
        end
        rd_chk("ctrl_rst", llc_pkg::ADDR_CTRL, 32'h0);
        rd_chk("fail_rst", llc_pkg::ADDR_FAIL, 32'h0);
        rd_chk("mask_rst", llc_pkg::ADDR_IRQ_MASK, 32'h0);
        // ch1 limits -50.00 .. 17.00, then refused settings and ch2 lower limit set to 299.99 and back
        wr(ca(0, llc_pkg::OFS_LOWER), 32'hffffec78, llc_pkg::RESP_OKAY);
        wr(ca(0, llc_pkg::OFS_UPPER), 32'h000006a4, llc_pkg::RESP_OKAY);
        wr(ca(0, llc_pkg::OFS_UPPER), 32'hffffe890, llc_pkg::RESP_SLVERR);
        wr(ca(0, llc_pkg::OFS_LOWER), 32'h000006a5, llc_pkg::RESP_SLVERR);
        wr(ca(1, llc_pkg::OFS_LOWER), 32'hffff8ad0, llc_pkg::RESP_SLVERR);
        wr(ca(1, llc_pkg::OFS_UPPER), 32'h00007530, llc_pkg::RESP_SLVERR);
        wr(ca(1, llc_pkg::OFS_LOWER), 32'h0000752f, llc_pkg::RESP_OKAY);
        wr(ca(1, llc_pkg::OFS_LOWER), 32'(llc_pkg::LOWER_RST), llc_pkg::RESP_OKAY);
        wr(8'hfc, 32'h1, llc_pkg::RESP_SLVERR);
        rd_chk("unmapped", 8'hfc, 32'h0);
        rd_chk("lower_ch1", ca(0, llc_pkg::OFS_LOWER), 32'hffffec78);
        rd_chk("upper_ch1", ca(0, llc_pkg::OFS_UPPER), 32'h000006a4);
        rd_chk("lower_ch2", ca(1, llc_pkg::OFS_LOWER), 32'(llc_pkg::LOWER_RST));
        sample(0, 5000, 1);
        rd_chk("count_off", ca(0, llc_pkg::OFS_COUNT), 32'h0);
        // both enabled; ch1 on sensor B then A, ch2 on a combination
        wr(llc_pkg::ADDR_CTRL, 32'h00000093, llc_pkg::RESP_OKAY);
        rd_chk("sensor_b", llc_pkg::ADDR_SENSOR, 32'h2);
        wr(llc_pkg::ADDR_CTRL, 32'h00000083, llc_pkg::RESP_OKAY);
        rd_chk("sensor_a", llc_pkg::ADDR_SENSOR, 32'h1);
        rd_chk("ctrl", llc_pkg::ADDR_CTRL, 32'h00000083);
        check("rresp", {30'h0, rresp}, {30'h0, llc_pkg::RESP_OKAY});
        sample(0, 0, 1);
        sample(0, 1700, 1);
        sample(0, -5000, 1);
        rd_chk("fail_in", llc_pkg::ADDR_FAIL, 32'h0);
        sample(0, 1701, 1);
        @(negedge clk_i);
        check("fail_o", {30'h0, fail_flags}, 32'h1);
        sample(0, -5001, 2);
        sample(0, 0, 1);
        rd_chk("count_ch1", ca(0, llc_pkg::OFS_COUNT), 32'h3);
        rd_chk("fail_ch1", llc_pkg::ADDR_FAIL, 32'h1);
        rd_chk("count_ch2", ca(1, llc_pkg::OFS_COUNT), 32'h0);
        sample(1, 30000, 1);
        rd_chk("count_ch2b", ca(1, llc_pkg::OFS_COUNT), 32'h1);
        rd_chk("irq_stat", llc_pkg::ADDR_IRQ_STAT, 32'h3);
        check("irq_masked", {31'h0, irq}, 32'h0);
        wr(llc_pkg::ADDR_IRQ_MASK, 32'h1, llc_pkg::RESP_OKAY);
        check("irq_on", {31'h0, irq}, 32'h1);
        wr(llc_pkg::ADDR_IRQ_STAT, 32'h1, llc_pkg::RESP_OKAY);
        check("irq_clr", {31'h0, irq}, 32'h0);
        wr(llc_pkg::ADDR_IRQ_MASK, 32'h2, llc_pkg::RESP_OKAY);
        check("irq_ch2", {31'h0, irq}, 32'h1);
        wr(llc_pkg::ADDR_IRQ_STAT, 32'h2, llc_pkg::RESP_OKAY);
        check("irq_off", {31'h0, irq}, 32'h0);
        wr(llc_pkg::ADDR_CLEAR, 32'h1, llc_pkg::RESP_OKAY);
        rd_chk("fail_clr", llc_pkg::ADDR_FAIL, 32'h2);
        rd_chk("count_clr", ca(0, llc_pkg::OFS_COUNT), 32'h0);
        sample(0, 2000, 1);
        rd_chk("count_new", ca(0, llc_pkg::OFS_COUNT), 32'h1);
        wr(llc_pkg::ADDR_CTRL, 32'h00000081, llc_pkg::RESP_OKAY);
        sample(1, 30000, 1);
        rd_chk("count_ch2_off", ca(1, llc_pkg::OFS_COUNT), 32'h1);
        wr(llc_pkg::ADDR_CTRL, 32'h00000083, llc_pkg::RESP_OKAY);
        rd_chk("count_restart", ca(1, llc_pkg::OFS_COUNT), 32'h0);
        rd_chk("fail_restart", llc_pkg::ADDR_FAIL, 32'h1);
        // second reset in mid-run
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("fail_reset", llc_pkg::ADDR_FAIL, 32'h0);
        rd_chk("ctrl_reset", llc_pkg::ADDR_CTRL, 32'h0);
        print_verdict();
    end
endmodule : tb
